// File: rtl/lkd_top.sv
// Purpose: derive a 64-bit transmitter crypt key while learning
// Assumes: code word and seed presented with their bit counts at start
// Notes: hop fields are split as received; decoding them is done elsewhere
//
// Overview of operation
// - normal or secure learning seed source
// - encoder type from received bit count
// - upper seed gives upper key half
// - normal: 6h and 2h prefix serial
// - secure: seed halves, prefix nibble zeroed
// - 32-bit seed: zero-topped serial, full seed
// - 48-bit seed: serial bits 23:12 and seed upper sixteen
// - 60-bit seed: upper 28 seed bits
// - decrypt method: cipher each seed, mfr key
// - xor method: seed halves xor mfr halves
// - algorithm select zero decrypt, one xor
// - config bit 2 enables secure learning
// - new mfr code triggers erase all
// - learn input low pulse ends indication
// - accept 66 to 69 bit code words
// - split hop: buttons, overflow, discrimination, sync
// - split fixed: status, function, serial
`timescale 1ns/10ps
`include "lkd_defs.svh"

module lkd_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // configuration and manufacturer code
   input wire logic [7:0] cfg_byte,
   input wire lkd_pkg::lkd_key_t mfr_code,
   input wire logic mfr_code_written,
   // learn control
   input wire logic learn_start,
   input wire logic learn_request_input,
   // received words
   input wire logic derive_req,
   input wire logic [68:0] code_word,
   input wire logic [6:0] code_bits,
   input wire logic [63:0] seed_word,
   input wire logic [6:0] seed_bits,
   // results
   output logic derive_done,
   output logic derive_error,
   output lkd_pkg::lkd_key_t crypt_key,
   output logic learn_indication,
   output logic erase_all,
   // parsed code word fields
   output logic [3:0] button_bits,
   output logic [1:0] overflow_bits,
   output logic [9:0] disc_bits,
   output logic [15:0] sync_value,
   output logic [1:0] status_bits,
   output logic [3:0] function_bits,
   output logic [31:0] serial_number
);
   import lkd_pkg::*;

   lkd_cipher_if cif ();

   lkd_state_t state, next_state;
   lkd_word_t upper_seed, lower_seed;
   lkd_word_t next_upper_seed, next_lower_seed;
   lkd_key_t next_crypt_key;
   logic next_derive_done, next_derive_error;
   logic use_xor, next_use_xor;
   logic start, next_start;
   logic learn_req_prev, next_learn_indication, next_erase_all;
   logic secure_sel, alg_sel, cw_ok, serial_32;
   logic [27:0] serial28;
   lkd_word_t in_upper, in_lower;
   logic seed_ok;

   // -------------------------------------------------------------
   // decryption core
   // -------------------------------------------------------------
   lkd_decrypt u_decrypt (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .cif(cif.core)
   );

   // cipher runs on one seed at a time, upper first
   assign cif.start = start;
   assign cif.data_in = (state == LKD_LOWER) ? lower_seed : upper_seed;
   assign cif.key = mfr_code;

   // -------------------------------------------------------------
   // seed composition
   // -------------------------------------------------------------
   // sampled at the strobe, so inputs may change once the request is taken
   always_comb begin
      alg_sel = cfg_byte[`LKD_CFG_ALG_BIT];
      secure_sel = cfg_byte[`LKD_CFG_SECURE_BIT];
      cw_ok = (code_bits >= `LKD_CW_BITS_MIN) && (code_bits <= `LKD_CW_BITS_MAX);
      serial_32 = code_bits > `LKD_CW_BITS_28_MAX;
      serial28 = code_word[`LKD_FIX_LSB +: 28];
      in_upper = 32'h00000000;
      in_lower = 32'h00000000;
      seed_ok = 1'b1;
      if (!secure_sel) begin
         in_upper = {`LKD_NIBBLE_UPPER, serial28};
         in_lower = {`LKD_NIBBLE_LOWER, serial28};
      end else if (seed_bits == `LKD_SEED_BITS_32) begin
         in_upper = {`LKD_NIBBLE_ZERO, serial28};
         in_lower = seed_word[31:0];
      end else if (seed_bits == `LKD_SEED_BITS_48) begin
         in_upper = {`LKD_NIBBLE_ZERO, serial28[23:12], seed_word[47:32]};
         in_lower = seed_word[31:0];
      end else if (seed_bits == `LKD_SEED_BITS_60) begin
         in_upper = {`LKD_NIBBLE_ZERO, seed_word[59:32]};
         in_lower = seed_word[31:0];
      end else begin
         seed_ok = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // derivation sequencer
   // -------------------------------------------------------------
   // the xor path needs no cipher, so it goes straight to finish and is done two cycles after the request
   always_comb begin
      next_state = state;
      next_upper_seed = upper_seed;
      next_lower_seed = lower_seed;
      next_use_xor = use_xor;
      next_crypt_key = crypt_key;
      next_derive_done = 1'b0;
      next_derive_error = 1'b0;
      next_start = 1'b0;
      case (state)
         LKD_IDLE: begin
            if (derive_req) begin
               if (!cw_ok || !seed_ok) begin
                  next_derive_error = 1'b1;
               end else begin
                  next_upper_seed = in_upper;
                  next_lower_seed = in_lower;
                  next_use_xor = alg_sel;
                  if (alg_sel) begin
                     next_state = LKD_FINISH;
                  end else begin
                     next_state = LKD_UPPER;
                     next_start = 1'b1;
                  end
               end
            end
         end
         LKD_UPPER: begin
            if (cif.done) begin
               next_crypt_key[63:32] = cif.data_out;
               next_state = LKD_LOWER;
               next_start = 1'b1;
            end
         end
         LKD_LOWER: begin
            if (cif.done) begin
               next_crypt_key[31:0] = cif.data_out;
               next_state = LKD_FINISH;
            end
         end
         LKD_FINISH: begin
            if (use_xor) begin
               next_crypt_key = {upper_seed ^ mfr_code[63:32],
                                 lower_seed ^ mfr_code[31:0]};
            end
            next_derive_done = 1'b1;
            next_state = LKD_IDLE;
         end
         default: begin
            next_state = LKD_IDLE;
         end
      endcase
   end

   // register the sequencer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= LKD_IDLE;
         upper_seed <= 32'h00000000;
         lower_seed <= 32'h00000000;
         use_xor <= 1'b0;
         crypt_key <= 64'h0000000000000000;
         derive_done <= 1'b0;
         derive_error <= 1'b0;
         start <= 1'b0;
      end else begin
         state <= next_state;
         upper_seed <= next_upper_seed;
         lower_seed <= next_lower_seed;
         use_xor <= next_use_xor;
         crypt_key <= next_crypt_key;
         derive_done <= next_derive_done;
         derive_error <= next_derive_error;
         start <= next_start;
      end
   end

   // -------------------------------------------------------------
   // learn indication and erase
   // -------------------------------------------------------------
   // a start in the same cycle as the low pulse keeps the indication on
   always_comb begin
      next_learn_indication = learn_indication;
      if (learn_req_prev && !learn_request_input) begin
         next_learn_indication = 1'b0;
      end
      if (learn_start) begin
         next_learn_indication = 1'b1;
      end
      next_erase_all = mfr_code_written;
   end

   // register indication, erase pulse and learn input history
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         learn_indication <= 1'b0;
         erase_all <= 1'b0;
         learn_req_prev <= 1'b1;
      end else begin
         learn_indication <= next_learn_indication;
         erase_all <= next_erase_all;
         learn_req_prev <= learn_request_input;
      end
   end

   // -------------------------------------------------------------
   // code word field split
   // -------------------------------------------------------------
   // fields latch on each idle strobe with a valid word length, even one refused for seed length; the guard gap leaves ample time
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         button_bits <= 4'h0;
         overflow_bits <= 2'h0;
         disc_bits <= 10'h000;
         sync_value <= 16'h0000;
         status_bits <= 2'h0;
         function_bits <= 4'h0;
         serial_number <= 32'h00000000;
      end else if (derive_req && state == LKD_IDLE && cw_ok) begin
         button_bits <= code_word[`LKD_HOP_BTN_LSB +: 4];
         overflow_bits <= code_word[`LKD_HOP_OVF_LSB +: 2];
         disc_bits <= code_word[`LKD_HOP_DISC_LSB +: 10];
         sync_value <= code_word[`LKD_HOP_SYNC_LSB +: 16];
         if (serial_32) begin
            serial_number <= code_word[`LKD_FIX_LSB +: 32];
            function_bits <= code_word[`LKD_FUNC_LSB_32 +: 4];
            status_bits <= {1'b0, code_word[68]};
         end else begin
            serial_number <= {`LKD_NIBBLE_ZERO, serial28};
            function_bits <= code_word[`LKD_FUNC_LSB_28 +: 4];
            status_bits <= code_word[`LKD_STAT_LSB_28 +: 2];
         end
      end
   end
endmodule : lkd_top

// File: rtl/lkd_defs.svh
// Purpose: named constants of the learn key derivation block
// Assumes: included by bare name from the package and modules
// Notes: definitions only
`ifndef LKD_DEFS_SVH
`define LKD_DEFS_SVH

// -------------------------------------------------------------
// configuration byte fields
// -------------------------------------------------------------
`define LKD_CFG_ALG_BIT 0
`define LKD_CFG_SECURE_BIT 2

// -------------------------------------------------------------
// code word layout
// -------------------------------------------------------------
`define LKD_CW_BITS_MIN 7'h42
`define LKD_CW_BITS_28_MAX 7'h43
`define LKD_CW_BITS_MAX 7'h45
`define LKD_HOP_BTN_LSB 28
`define LKD_HOP_OVF_LSB 26
`define LKD_HOP_DISC_LSB 16
`define LKD_HOP_SYNC_LSB 0
`define LKD_FIX_LSB 32
`define LKD_FUNC_LSB_28 60
`define LKD_STAT_LSB_28 64
`define LKD_FUNC_LSB_32 64

// -------------------------------------------------------------
// seed lengths and prefix nibbles
// -------------------------------------------------------------
`define LKD_SEED_BITS_32 7'h20
`define LKD_SEED_BITS_48 7'h30
`define LKD_SEED_BITS_60 7'h3c
`define LKD_NIBBLE_UPPER 4'h6
`define LKD_NIBBLE_LOWER 4'h2
`define LKD_NIBBLE_ZERO 4'h0

// -------------------------------------------------------------
// block cipher
// -------------------------------------------------------------
`define LKD_ROUNDS 10'h210
`define LKD_NLF_TABLE 32'h3a5c742e
`define LKD_KEY_TAP_BASE 6'h0f

`endif

// File: rtl/lkd_pkg.sv
// Purpose: shared types of the learn key derivation block
// Assumes: lkd_defs.svh on the include path
// Notes: constants live in the header, types here
`include "lkd_defs.svh"

package lkd_pkg;

   // -------------------------------------------------------------
   // sequencer states, one-hot
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      LKD_IDLE = 4'h1,
      LKD_UPPER = 4'h2,
      LKD_LOWER = 4'h4,
      LKD_FINISH = 4'h8
   } lkd_state_t;

   typedef logic [31:0] lkd_word_t;
   typedef logic [63:0] lkd_key_t;

endpackage : lkd_pkg

// File: rtl/lkd_cipher_if.sv
// Purpose: carrier between sequencer and decryption core
// Assumes: single clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/10ps

interface lkd_cipher_if;
   logic start;
   logic [31:0] data_in;
   logic [63:0] key;
   logic done;
   logic [31:0] data_out;

   modport seq (output start, output data_in, output key, input done, input data_out);
   modport core (input start, input data_in, input key, output done, output data_out);
endinterface : lkd_cipher_if

// File: rtl/lkd_decrypt.sv
// Purpose: iterative 32-bit block decryption, one round per clock
// Assumes: data_in and key held stable from start until done
// Notes: a new start while busy is ignored
`timescale 1ns/10ps
`include "lkd_defs.svh"

module lkd_decrypt (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // link to the sequencer
   lkd_cipher_if.core cif
);
   import lkd_pkg::*;

   logic busy, next_busy;
   logic [9:0] round, next_round;
   lkd_word_t state, next_state;
   logic done, next_done;
   logic [5:0] tap;
   lkd_word_t nlf_table;
   logic [4:0] nlf_idx;
   logic fb;

   // -------------------------------------------------------------
   // round logic
   // -------------------------------------------------------------
   // the key tap walks backwards so the rounds undo encryption in reverse
   always_comb begin
      tap = `LKD_KEY_TAP_BASE - round[5:0];
      nlf_idx = {state[30], state[25], state[19], state[8], state[0]};
      // a literal cannot be bit-selected, so the table goes through a variable
      nlf_table = `LKD_NLF_TABLE;
      fb = state[31] ^ state[15] ^ cif.key[tap] ^ nlf_table[nlf_idx];
      next_busy = busy;
      next_round = round;
      next_state = state;
      next_done = 1'b0;
      if (!busy && cif.start) begin
         next_busy = 1'b1;
         next_round = 10'h000;
         next_state = cif.data_in;
      end else if (busy) begin
         next_state = {state[30:0], fb};
         next_round = round + 10'h001;
         if (round == `LKD_ROUNDS - 10'h001) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   // register the round state
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy <= 1'b0;
         round <= 10'h000;
         state <= 32'h00000000;
         done <= 1'b0;
      end else begin
         busy <= next_busy;
         round <= next_round;
         state <= next_state;
         done <= next_done;
      end
   end

   assign cif.done = done;
   assign cif.data_out = state;
endmodule : lkd_decrypt

// File: test/lkd_props.sv
// Purpose: port-level checks of lkd_top
// Assumes: one clock, synchronous reset
// Notes: busy state and cycle count are rebuilt here from the ports
`timescale 1ns/10ps

module lkd_props (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // inputs watched
   input wire logic [7:0] cfg_byte,
   input wire logic mfr_code_written,
   input wire logic learn_start,
   input wire logic learn_request_input,
   input wire logic derive_req,
   input wire logic [68:0] code_word,
   input wire logic [6:0] code_bits,
   input wire logic [6:0] seed_bits,
   // outputs watched
   input wire logic derive_done,
   input wire logic derive_error,
   input wire logic learn_indication,
   input wire logic erase_all,
   input wire logic [3:0] button_bits,
   input wire logic [15:0] sync_value,
   input wire logic [1:0] status_bits,
   input wire logic [3:0] function_bits
);
   logic busy, next_busy, lat_xor, next_lat_xor, cw_ok, ok_len, acc, bad_acc;
   logic [10:0] cnt, next_cnt;

   // -------------------------------------------------------------
   // request tracking
   // -------------------------------------------------------------
   // a request counts while idle or in the cycle that ends a run; else dropped
   assign cw_ok = code_bits >= 7'h42 && code_bits <= 7'h45;
   assign ok_len = cw_ok && (!cfg_byte[2] || seed_bits == 7'h20 || seed_bits == 7'h30 ||
      seed_bits == 7'h3c);
   assign acc = derive_req && (!busy || derive_done || derive_error);
   assign bad_acc = acc && !ok_len;
   // next busy state, latency count and latched method
   always_comb begin
      next_busy = acc || (busy && !(derive_done || derive_error));
      next_cnt = acc ? 11'h001 : (busy ? cnt + 11'h001 : cnt);
      next_lat_xor = acc ? cfg_byte[0] : lat_xor;
   end
   // registers of the tracking state
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy <= 1'b0;
         cnt <= 11'h000;
         lat_xor <= 1'b0;
      end else begin
         busy <= next_busy;
         cnt <= next_cnt;
         lat_xor <= next_lat_xor;
      end
   end

   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   property p_fields;
      logic [68:0] w;
      (acc && cw_ok, w = code_word) |=> sync_value == w[15:0] && button_bits == w[31:28];
   endproperty
   property p_fixed;
      logic [68:0] w;
      (acc && code_bits == 7'h42, w = code_word) |=>
         function_bits == w[63:60] && status_bits == w[65:64];
   endproperty

   a_erase_follows: assert property (mfr_code_written |=> erase_all)
      else $error("erase did not follow a new code");
   a_erase_cause: assert property (erase_all |-> $past(mfr_code_written))
      else $error("erase without a new code");
   a_learn_set: assert property (learn_start |=> learn_indication)
      else $error("learn indication not set");
   a_learn_end: assert property ($fell(learn_request_input) && !learn_start
      |=> !learn_indication)
      else $error("learn indication not ended");
   a_bad_length: assert property (bad_acc |=> derive_error)
      else $error("bad length not refused");
   a_error_cause: assert property (derive_error |-> $past(bad_acc))
      else $error("error without a bad length");
   a_done_timing: assert property (derive_done |-> busy && (lat_xor ? cnt == 11'h002 :
      cnt > 11'h410 && cnt < 11'h438))
      else $error("done at the wrong cycle");
   a_no_hang: assert property (busy |-> cnt < 11'h44c)
      else $error("derivation never finished");
   a_fields_latch: assert property (p_fields)
      else $error("hop fields not latched");
   a_fixed_fields: assert property (p_fixed)
      else $error("fixed fields not latched");

   c_xor_done: cover property (derive_done && lat_xor);
   c_dec_done: cover property (derive_done && !lat_xor);
   c_error: cover property (derive_error);
   c_learn_end: cover property ($fell(learn_indication));
endmodule : lkd_props

bind lkd_top lkd_props lkd_props_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_byte(cfg_byte),
   .mfr_code_written(mfr_code_written), .learn_start(learn_start),
   .learn_request_input(learn_request_input), .derive_req(derive_req), .code_word(code_word),
   .code_bits(code_bits), .seed_bits(seed_bits), .derive_done(derive_done),
   .derive_error(derive_error), .learn_indication(learn_indication), .erase_all(erase_all),
   .button_bits(button_bits), .sync_value(sync_value), .status_bits(status_bits),
   .function_bits(function_bits));

// File: test/lkd_encoder_model.sv
// Purpose: remote encoder as seen through the receiver
// Assumes: the bench says when a word is on air
// Notes: off air the code and seed word lines show the inverse, never a held copy; the bit counts stay as set
`timescale 1ns/10ps

module lkd_encoder_model (
   // word content
   input wire logic on_air,
   input wire logic [6:0] word_len,
   input wire logic [31:0] hop,
   input wire logic [31:0] serial,
   input wire logic [3:0] func,
   input wire logic [1:0] stat,
   input wire logic [63:0] seed,
   input wire logic [6:0] seed_len,
   // received lines
   output logic [68:0] code_word,
   output logic [6:0] code_bits,
   output logic [63:0] seed_word,
   output logic [6:0] seed_bits
);
   logic [68:0] w;

   // hop part first; long words carry the full 32-bit serial
   always_comb begin
      if (word_len >= 7'h44) begin
         w = {stat[0], func, serial, hop};
      end else begin
         w = {3'h0, stat, func, serial[27:0], hop};
      end
      code_word = on_air ? w : ~w;
      seed_word = on_air ? seed : ~seed;
      code_bits = word_len;
      seed_bits = seed_len;
   end
endmodule : lkd_encoder_model

// File: test/tb_top.sv
// Purpose: self-checking bench of lkd_top
// Assumes: 250 MHz clock, inputs driven on the falling edge
// Notes: reference keys are rebuilt here from the seed layouts
`timescale 1ns/10ps
`include "lkd_defs.svh"

module tb_top;
   import lkd_pkg::*;
   logic ref_clk = 1'b0, sys_rst = 1'b1, mfr_code_written = 1'b0, learn_start = 1'b0;
   logic learn_request_input = 1'b1, derive_req = 1'b0, on_air = 1'b0, err;
   logic [7:0] cfg_byte = 8'h00;
   logic [6:0] word_len = 7'h42, seed_len = 7'h20, code_bits, seed_bits;
   logic [31:0] hop = 32'h0, serial = 32'h0, serial_number, rng = 32'h4019dfd6;
   logic [3:0] func = 4'h0, button_bits, function_bits;
   logic [1:0] stat = 2'h0, overflow_bits, status_bits;
   logic [63:0] seed = 64'h0, seed_word;
   logic [68:0] code_word;
   logic derive_done, derive_error, learn_indication, erase_all;
   logic [9:0] disc_bits;
   logic [15:0] sync_value;
   lkd_key_t mfr_code = 64'h0, crypt_key, held;
   int mismatches = 0, checks_done = 0, cycles = 0;

   always #2 ref_clk = ~ref_clk;

   lkd_top lkd_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_byte(cfg_byte),
      .mfr_code(mfr_code), .mfr_code_written(mfr_code_written), .learn_start(learn_start),
      .learn_request_input(learn_request_input), .derive_req(derive_req),
      .code_word(code_word), .code_bits(code_bits), .seed_word(seed_word),
      .seed_bits(seed_bits), .derive_done(derive_done), .derive_error(derive_error),
      .crypt_key(crypt_key), .learn_indication(learn_indication), .erase_all(erase_all),
      .button_bits(button_bits), .overflow_bits(overflow_bits), .disc_bits(disc_bits),
      .sync_value(sync_value), .status_bits(status_bits), .function_bits(function_bits),
      .serial_number(serial_number));
   lkd_encoder_model lkd_encoder_model_i (.on_air(on_air), .word_len(word_len), .hop(hop),
      .serial(serial), .func(func), .stat(stat), .seed(seed), .seed_len(seed_len),
      .code_word(code_word), .code_bits(code_bits), .seed_word(seed_word),
      .seed_bits(seed_bits));

   // -------------------------------------------------------------
   // reference model and helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] next_rand();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : next_rand

   // one cipher round per pass, feedback shifted in at bit 0
   function automatic logic [31:0] ref_dec(logic [31:0] d, logic [63:0] k);
      logic [31:0] tbl;
      tbl = `LKD_NLF_TABLE;
      for (int r = 0; r < `LKD_ROUNDS; r++) begin
         d = {d[30:0], d[31] ^ d[15] ^ k[(15 - r) & 63] ^ tbl[{d[30], d[25], d[19], d[8], d[0]}]};
      end
      return d;
   endfunction : ref_dec

   function automatic lkd_key_t ref_key();
      logic [31:0] up, lo;
      up = {4'h6, serial[27:0]};
      lo = {4'h2, serial[27:0]};
      if (cfg_byte[2]) begin
         lo = seed[31:0];
         case (seed_len)
            7'h20: up = {4'h0, serial[27:0]};
            7'h30: up = {4'h0, serial[23:12], seed[47:32]};
            default: up = {4'h0, seed[59:32]};
         endcase
      end
      if (cfg_byte[0]) return {up, lo} ^ mfr_code;
      return {ref_dec(up, mfr_code), ref_dec(lo, mfr_code)};
   endfunction : ref_key

   task automatic check(logic [63:0] got, logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // put a fresh word on air, request once, wait for the answer
   task automatic derive(logic [7:0] cfg, logic [6:0] wl, logic [6:0] sl);
      int n;
      @(negedge ref_clk);
      cfg_byte = cfg;
      word_len = wl;
      seed_len = sl;
      hop = next_rand();
      serial = next_rand();
      seed = {next_rand(), next_rand()};
      mfr_code = {next_rand(), next_rand()};
      func = 4'(next_rand());
      stat = 2'(next_rand());
      on_air = 1'b1;
      derive_req = 1'b1;
      @(negedge ref_clk);
      derive_req = 1'b0;
      n = 0;
      while (derive_done !== 1'b1 && derive_error !== 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      err = derive_error;
      on_air = 1'b0;
   endtask : derive

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   // -------------------------------------------------------------
   // sequence
   // -------------------------------------------------------------
   // hang guard, far above two decrypt runs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // scenario tables, kept at module level so their initialisers run once
   logic [7:0] cfgs[9] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h05, 8'h05, 8'h05, 8'h00, 8'h04};
   logic [6:0] wls[9] = '{7'h42, 7'h43, 7'h44, 7'h45, 7'h42, 7'h44, 7'h45, 7'h43, 7'h45};
   logic [6:0] sls[9] = '{7'h20, 7'h20, 7'h20, 7'h20, 7'h20, 7'h30, 7'h3c, 7'h20, 7'h30};
   logic [6:0] bad[3] = '{7'h41, 7'h46, 7'h42};

   initial begin
      logic [37:0] fix_exp;
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      // every word length, every seed length, both methods
      for (int i = 0; i < 9; i++) begin
         derive(cfgs[i], wls[i], sls[i]);
         check(64'(err), 64'h0);
         check(crypt_key, ref_key());
         check(64'({button_bits, overflow_bits, disc_bits, sync_value}), 64'(hop));
         // long words carry a full serial and a single status bit
         fix_exp = {stat, func, 4'h0, serial[27:0]};
         if (wls[i] >= 7'h44) begin
            fix_exp = {1'b0, stat[0], func, serial};
         end
         check(64'({status_bits, function_bits, serial_number}), 64'(fix_exp));
         $display("derive test %0d done", i);
      end
      // bad lengths are refused and leave the key alone
      for (int i = 0; i < 3; i++) begin
         held = crypt_key;
         derive({5'h00, i == 2, 2'h1}, bad[i], 7'h28);
         check(64'(err), 64'h1);
         check(crypt_key, held);
      end
      $display("refusal test done");
      // new manufacturer code wipes the learned set
      mfr_code_written = 1'b1;
      @(negedge ref_clk);
      mfr_code_written = 1'b0;
      check(64'(erase_all), 64'h1);
      @(negedge ref_clk);
      check(64'(erase_all), 64'h0);
      $display("erase test done");
      // brief low on the learn input ends the indication
      learn_start = 1'b1;
      @(negedge ref_clk);
      learn_start = 1'b0;
      check(64'(learn_indication), 64'h1);
      repeat (3) @(negedge ref_clk);
      learn_request_input = 1'b0;
      @(negedge ref_clk);
      learn_request_input = 1'b1;
      check(64'(learn_indication), 64'h0);
      $display("learn test done");
      tally_and_finish();
   end
endmodule : tb_top
